// *** verilog/csfr_status_reg.sv ***
// Cpu status flag register: masked file writes, ALU flags, reset-cause flags
`timescale 1ns/1ns
module csfr_status_reg
(
   // Clock, reset and enable
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   input wire logic CLK_EN,
   // Executing instruction
   input wire logic EXEC,
   input wire csfr_pkg::csfr_op_e OP,
   input wire logic [7:0] OPND_A,
   input wire logic [7:0] OPND_B,
   input wire logic [2:0] BIT_SEL,
   input wire logic DEST_FILE,
   input wire logic [csfr_pkg::DATA_ADDR_W-1:0] FILE_ADDR,
   // Core events
   input wire logic WDT_TIMEOUT,
   input wire logic WATCHDOG_CLEAR_INSTR,
   input wire logic SLEEP_INSTR,
   // Data address forming
   input wire logic [csfr_pkg::FILE_OFS_W-1:0] INSTR_FILE,
   input wire logic [7:0] INDIRECT_PTR,
   output logic [csfr_pkg::DATA_ADDR_W-1:0] DIRECT_ADDR,
   output logic [csfr_pkg::DATA_ADDR_W-1:0] INDIRECT_ADDR,
   // Register contents and last result
   output logic [7:0] STATUS_VALUE,
   output logic [7:0] ALU_RESULT
);
   import csfr_pkg::*;

   csfr_state_s st;
   csfr_state_s next_st;
   logic [7:0] alu_result;
   logic alu_z;
   logic alu_dc;
   logic alu_c;
   logic upd_z;
   logic upd_dc;
   logic upd_c;
   logic alu_sets_flags;
   logic wr_hit;
   logic [7:0] wr_mask;
   logic no_event;

   csfr_flag_alu u_alu
   (
      .op(OP),
      .opnd_a(OPND_A),
      .opnd_b(OPND_B),
      .bit_sel(BIT_SEL),
      .carry_in(st.status[POS_CARRY_FLAG]),
      .result(alu_result),
      .z(alu_z),
      .dc(alu_dc),
      .c(alu_c),
      .upd_z(upd_z),
      .upd_dc(upd_dc),
      .upd_c(upd_c)
   );

   assign alu_sets_flags = upd_z | upd_dc | upd_c;
   assign wr_hit = EXEC && DEST_FILE && csfr_status_hit(FILE_ADDR);
   assign no_event = !WDT_TIMEOUT && !WATCHDOG_CLEAR_INSTR && !SLEEP_INSTR;

   // Any flag-affecting op locks all three arithmetic bits, so clear-file
   // keeps digit carry and carry even though it only computes zero
   assign wr_mask = alu_sets_flags ? (STATUS_WRITABLE & ~STATUS_ARITH)
                                   : STATUS_WRITABLE;

   always_comb
   begin
      next_st = st;
      if (wr_hit)
      begin
         next_st.status = (st.status & ~wr_mask) | (alu_result & wr_mask);
      end
      if (EXEC)
      begin
         next_st.result = alu_result;
         if (upd_z)
         begin
            next_st.status[POS_ZERO_FLAG] = alu_z;
         end
         if (upd_dc)
         begin
            next_st.status[POS_DIGIT_CARRY_FLAG] = alu_dc;
         end
         if (upd_c)
         begin
            next_st.status[POS_CARRY_FLAG] = alu_c;
         end
      end
      if (WATCHDOG_CLEAR_INSTR)
      begin
         next_st.status[POS_TIMEOUT_FLAG] = 1'b1;
         next_st.status[POS_POWERDOWN_FLAG] = 1'b1;
      end
      if (SLEEP_INSTR)
      begin
         next_st.status[POS_TIMEOUT_FLAG] = 1'b1;
         next_st.status[POS_POWERDOWN_FLAG] = 1'b0;
      end
      // A time-out is the event that must not be masked by a same-cycle clear
      if (WDT_TIMEOUT)
      begin
         next_st.status[POS_TIMEOUT_FLAG] = 1'b0;
      end
   end

   // Reset acts even while the clock enable is low
   always_ff @(posedge CORE_CLK)
   begin
      if (!RESET_N)
      begin
         st <= STATE_RESET;
      end
      else if (CLK_EN)
      begin
         st <= next_st;
      end
   end

   assign STATUS_VALUE = st.status;
   assign ALU_RESULT = st.result;
   assign DIRECT_ADDR = {st.status[POS_DIRECT_BANK_SELECT_HI:POS_DIRECT_BANK_SELECT_LO],
                         INSTR_FILE};
   assign INDIRECT_ADDR = {st.status[POS_INDIRECT_BANK_SELECT], INDIRECT_PTR};

   a_flag_write_lock: assert property (
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (CLK_EN && wr_hit && upd_c) |=> (STATUS_VALUE[0] == $past(alu_c)))
      else $error("carry took the written value instead of the computed one");

   a_cause_unwritable: assert property (
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (CLK_EN && wr_hit && no_event) |=> (STATUS_VALUE[4:3] == $past(STATUS_VALUE[4:3])))
      else $error("reset-cause flags changed by an instruction write");

   a_clear_file: assert property (
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (CLK_EN && wr_hit && OP == OP_CLR && no_event) |=>
      (STATUS_VALUE == {3'b000, $past(STATUS_VALUE[4:3]), 1'b1, $past(STATUS_VALUE[1:0])}))
      else $error("clear-file result on the status register is wrong");

   a_sub_borrow: assert property (
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (CLK_EN && EXEC && OP == OP_SUB) |=>
      (STATUS_VALUE[0] == ($past(OPND_A) >= $past(OPND_B))) &&
      (STATUS_VALUE[1] == ($past(OPND_A[3:0]) >= $past(OPND_B[3:0]))))
      else $error("subtract carry or digit carry is not the inverted borrow");

   a_indirect_bank: assert property (
      @(posedge CORE_CLK) disable iff (!RESET_N)
      STATUS_VALUE[7] ? (INDIRECT_ADDR >= 9'h100) : (INDIRECT_ADDR <= 9'h0FF))
      else $error("indirect address outside the selected bank pair");

   a_direct_bank: assert property (
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (STATUS_VALUE[6:5] == 2'b10) |-> (DIRECT_ADDR >= 9'h100 && DIRECT_ADDR <= 9'h17F))
      else $error("direct address outside bank 2");

   a_timeout_event: assert property (
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (CLK_EN && WDT_TIMEOUT) |=> !STATUS_VALUE[4])
      else $error("time-out flag not cleared by a watchdog time-out");

   a_sleep_entry: assert property (
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (CLK_EN && SLEEP_INSTR && !WDT_TIMEOUT) |=> (STATUS_VALUE[4:3] == 2'b10))
      else $error("sleep did not leave time-out set and power-down clear");

   a_zero_flag: assert property (
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (CLK_EN && EXEC && upd_z) |=> (STATUS_VALUE[2] == (ALU_RESULT == 8'h00)))
      else $error("zero flag disagrees with the result");

   a_add_carries: assert property (
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (CLK_EN && EXEC && OP == OP_ADD) |=>
      (STATUS_VALUE[1] == (({1'b0, $past(OPND_A[3:0])} + {1'b0, $past(OPND_B[3:0])}) > 5'h0F)) &&
      (STATUS_VALUE[0] == (({1'b0, $past(OPND_A)} + {1'b0, $past(OPND_B)}) > 9'h0FF)))
      else $error("add carry or digit carry is wrong");

   a_rotate_carry: assert property (
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (CLK_EN && EXEC && OP == OP_ROTL) |=> (STATUS_VALUE[0] == $past(OPND_A[7])))
      else $error("rotate left did not load carry from the high bit");

   a_reset_values: assert property (
      @(posedge CORE_CLK)
      (!$past(RESET_N) && RESET_N) |-> (STATUS_VALUE[7:3] == 5'b00011))
      else $error("status bits 7:3 wrong after reset");

   a_mirror_write: assert property (
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (CLK_EN && EXEC && DEST_FILE && FILE_ADDR == 9'h083 && OP == OP_MOVE) |=>
      (STATUS_VALUE[7:5] == $past(OPND_A[7:5])))
      else $error("write at the upper mirror address missed the register");

   a_plain_write: assert property (
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (CLK_EN && wr_hit && !alu_sets_flags && no_event) |=>
      ((STATUS_VALUE & STATUS_WRITABLE) == ($past(alu_result) & STATUS_WRITABLE)))
      else $error("flagless write did not store every writable bit");

   a_rotate_right: assert property (
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (CLK_EN && EXEC && OP == OP_ROTR) |=> (STATUS_VALUE[0] == $past(OPND_A[0])))
      else $error("rotate right did not load carry from the low bit");

   a_wdt_clear: assert property (
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (CLK_EN && WATCHDOG_CLEAR_INSTR && !SLEEP_INSTR && !WDT_TIMEOUT) |=>
      (STATUS_VALUE[4:3] == 2'b11))
      else $error("watchdog clear did not set time-out and power-down");

   a_direct_bank_zero: assert property (
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (STATUS_VALUE[6:5] == 2'b00) |-> (DIRECT_ADDR <= 9'h07F))
      else $error("direct address outside bank 0");

   a_direct_bank_one: assert property (
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (STATUS_VALUE[6:5] == 2'b01) |-> (DIRECT_ADDR >= 9'h080 && DIRECT_ADDR <= 9'h0FF))
      else $error("direct address outside bank 1");

   a_direct_bank_top: assert property (
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (STATUS_VALUE[6:5] == 2'b11) |-> (DIRECT_ADDR >= 9'h180))
      else $error("direct address outside bank 3");
endmodule

// *** verilog/csfr_pkg.sv ***
// Package for the cpu status flag register: addresses, bit layout, operations
package csfr_pkg;
   localparam int DATA_ADDR_W = 9;
   localparam int FILE_OFS_W = 7;
   localparam logic [8:0] STATUS_ADDR_BANK0 = 9'h003;
   localparam logic [8:0] STATUS_ADDR_BANK1 = 9'h083;
   localparam int POS_INDIRECT_BANK_SELECT = 7;
   localparam int POS_DIRECT_BANK_SELECT_HI = 6;
   localparam int POS_DIRECT_BANK_SELECT_LO = 5;
   localparam int POS_TIMEOUT_FLAG = 4;
   localparam int POS_POWERDOWN_FLAG = 3;
   localparam int POS_ZERO_FLAG = 2;
   localparam int POS_DIGIT_CARRY_FLAG = 1;
   localparam int POS_CARRY_FLAG = 0;
   localparam logic [7:0] STATUS_RESET = 8'h18;
   localparam logic [7:0] STATUS_WRITABLE = 8'hE7;
   localparam logic [7:0] STATUS_ARITH = 8'h07;

   typedef enum logic [3:0] {
      OP_MOVE   = 4'h0,
      OP_ADD    = 4'h1,
      OP_SUB    = 4'h2,
      OP_AND    = 4'h3,
      OP_IOR    = 4'h4,
      OP_XOR    = 4'h5,
      OP_COM    = 4'h6,
      OP_INC    = 4'h7,
      OP_DEC    = 4'h8,
      OP_MOVZ   = 4'h9,
      OP_CLR    = 4'hA,
      OP_ROTL   = 4'hB,
      OP_ROTR   = 4'hC,
      OP_SWAP   = 4'hD,
      OP_BITCLR = 4'hE,
      OP_BITSET = 4'hF
   } csfr_op_e;

   typedef struct packed {
      logic [7:0] status;
      logic [7:0] result;
   } csfr_state_s;

   localparam csfr_state_s STATE_RESET = '{status: STATUS_RESET, result: 8'h00};

   // Both mirror addresses reach the one physical register
   function automatic logic csfr_status_hit(input logic [8:0] addr);
      return (addr == STATUS_ADDR_BANK0) || (addr == STATUS_ADDR_BANK1);
   endfunction
endpackage

// *** verilog/csfr_flag_alu.sv ***
// Flag-generating ALU: result, zero, digit carry and carry with update enables
`timescale 1ns/1ns
module csfr_flag_alu
(
   // Operation and operands
   input wire csfr_pkg::csfr_op_e op,
   input wire logic [7:0] opnd_a,
   input wire logic [7:0] opnd_b,
   input wire logic [2:0] bit_sel,
   input wire logic carry_in,
   // Result and flags
   output logic [7:0] result,
   output logic z,
   output logic dc,
   output logic c,
   output logic upd_z,
   output logic upd_dc,
   output logic upd_c
);
   import csfr_pkg::*;

   logic [8:0] sum9;
   logic [4:0] nib5;

   always_comb
   begin
      sum9 = 9'h000;
      nib5 = 5'h00;
      result = opnd_a;
      dc = 1'b0;
      c = 1'b0;
      upd_z = 1'b0;
      upd_dc = 1'b0;
      upd_c = 1'b0;
      unique case (op)
         OP_MOVE: result = opnd_a;
         OP_ADD:
         begin
            sum9 = {1'b0, opnd_a} + {1'b0, opnd_b};
            nib5 = {1'b0, opnd_a[3:0]} + {1'b0, opnd_b[3:0]};
            result = sum9[7:0];
            c = sum9[8];
            dc = nib5[4];
            upd_z = 1'b1;
            upd_dc = 1'b1;
            upd_c = 1'b1;
         end
         OP_SUB:
         begin
            // Adding the two's complement makes carry-out read as no-borrow
            sum9 = {1'b0, opnd_a} + {1'b0, ~opnd_b} + 9'h001;
            nib5 = {1'b0, opnd_a[3:0]} + {1'b0, ~opnd_b[3:0]} + 5'h01;
            result = sum9[7:0];
            c = sum9[8];
            dc = nib5[4];
            upd_z = 1'b1;
            upd_dc = 1'b1;
            upd_c = 1'b1;
         end
         OP_AND:
         begin
            result = opnd_a & opnd_b;
            upd_z = 1'b1;
         end
         OP_IOR:
         begin
            result = opnd_a | opnd_b;
            upd_z = 1'b1;
         end
         OP_XOR:
         begin
            result = opnd_a ^ opnd_b;
            upd_z = 1'b1;
         end
         OP_COM:
         begin
            result = ~opnd_a;
            upd_z = 1'b1;
         end
         OP_INC:
         begin
            result = opnd_a + 8'h01;
            upd_z = 1'b1;
         end
         OP_DEC:
         begin
            result = opnd_a - 8'h01;
            upd_z = 1'b1;
         end
         OP_MOVZ: upd_z = 1'b1;
         OP_CLR:
         begin
            result = 8'h00;
            upd_z = 1'b1;
         end
         OP_ROTL:
         begin
            result = {opnd_a[6:0], carry_in};
            c = opnd_a[7];
            upd_c = 1'b1;
         end
         OP_ROTR:
         begin
            result = {carry_in, opnd_a[7:1]};
            c = opnd_a[0];
            upd_c = 1'b1;
         end
         OP_SWAP: result = {opnd_a[3:0], opnd_a[7:4]};
         OP_BITCLR: result = opnd_a & ~(8'h01 << bit_sel);
         OP_BITSET: result = opnd_a | (8'h01 << bit_sel);
      endcase
      z = (result == 8'h00);
   end
endmodule

// *** test/csfr_datapath_model.sv ***
// Datapath model that drives the status register's instruction and event inputs
`timescale 1ns/1ns
module csfr_datapath_model
(
   // Clock
   input wire logic core_clk,
   // Clock enable and instruction fields
   output logic clk_en,
   output logic exec,
   output csfr_pkg::csfr_op_e op,
   output logic [7:0] opnd_a,
   output logic [7:0] opnd_b,
   output logic [2:0] bit_sel,
   output logic dest_file,
   output logic [csfr_pkg::DATA_ADDR_W-1:0] file_addr,
   output logic [csfr_pkg::FILE_OFS_W-1:0] instr_file,
   output logic [7:0] indirect_ptr,
   // Core events
   output logic wdt_timeout,
   output logic watchdog_clear_instr,
   output logic sleep_instr
);
   import csfr_pkg::*;

   initial
   begin
      op = OP_MOVE;
      {clk_en, exec, dest_file, wdt_timeout, watchdog_clear_instr, sleep_instr} = 6'h20;
      {opnd_a, opnd_b, bit_sel, file_addr, instr_file, indirect_ptr} = '0;
   end

   // One instruction, taken at the rising edge between two falling edges
   task automatic instr(input csfr_op_e o, input logic [7:0] a, input logic [7:0] b,
      input logic [2:0] bs, input logic d, input logic [8:0] addr);
      @(negedge core_clk);
      op = o;
      {exec, opnd_a, opnd_b, bit_sel, dest_file, file_addr} = {1'b1, a, b, bs, d, addr};
      {instr_file, indirect_ptr} = {a[6:0], b};
      @(negedge core_clk);
      // Idle fields turn over so a stray sample never looks like the last request
      {exec, opnd_a, opnd_b, file_addr} = {1'b0, ~a, ~b, ~addr};
   endtask

   // One-cycle event pulses; en low shows that a frozen core ignores them
   task automatic ev(input logic en, input logic w, input logic c, input logic s);
      @(negedge core_clk);
      {clk_en, wdt_timeout, watchdog_clear_instr, sleep_instr} = {en, w, c, s};
      @(negedge core_clk);
      {clk_en, wdt_timeout, watchdog_clear_instr, sleep_instr} = 4'h8;
   endtask
endmodule

// *** test/cpu_status_flag_register_tb.sv ***
// Self-checking bench for the cpu status flag register
`timescale 1ns/1ns
module cpu_status_flag_register_tb;
   import csfr_pkg::*;
   logic core_clk, reset_n, clk_en, exec, dest_file, wdt_timeout, wd_clear, sleep_instr;
   csfr_op_e op;
   logic [7:0] opnd_a, opnd_b, indirect_ptr, status_value, alu_result, exp_status, v;
   logic [2:0] bit_sel;
   logic [8:0] file_addr, direct_addr, indirect_addr;
   logic [6:0] instr_file;
   logic [10:0] r;
   int bad_count, comparisons;
   // Subtract flag, a, b
   logic [16:0] arith_tab [0:6] = '{17'h00F01, 17'h0FF01, 17'h08080, 17'h10503, 17'h10305,
      17'h11001, 17'h12222};
   // Op, a, b, result for operations that touch only the zero flag
   logic [27:0] zero_tab [0:6] = '{28'h30FF000, 28'h4000101, 28'h5555500, 28'h6FF0000,
      28'h7FF0000, 28'h8010000, 28'h9070007};

   initial core_clk = 1'b0;
   always #4 core_clk = ~core_clk;

   csfr_status_reg csfr_status_reg_i (.CORE_CLK(core_clk), .RESET_N(reset_n), .CLK_EN(clk_en),
      .EXEC(exec), .OP(op), .OPND_A(opnd_a), .OPND_B(opnd_b), .BIT_SEL(bit_sel),
      .DEST_FILE(dest_file), .FILE_ADDR(file_addr), .WDT_TIMEOUT(wdt_timeout),
      .WATCHDOG_CLEAR_INSTR(wd_clear), .SLEEP_INSTR(sleep_instr), .INSTR_FILE(instr_file),
      .INDIRECT_PTR(indirect_ptr), .DIRECT_ADDR(direct_addr), .INDIRECT_ADDR(indirect_addr),
      .STATUS_VALUE(status_value), .ALU_RESULT(alu_result));
   csfr_datapath_model csfr_datapath_model_i (.core_clk(core_clk), .clk_en(clk_en),
      .exec(exec), .op(op), .opnd_a(opnd_a), .opnd_b(opnd_b), .bit_sel(bit_sel),
      .dest_file(dest_file), .file_addr(file_addr), .instr_file(instr_file),
      .indirect_ptr(indirect_ptr), .wdt_timeout(wdt_timeout),
      .watchdog_clear_instr(wd_clear), .sleep_instr(sleep_instr));

   task automatic chk(input logic [8:0] seen, input logic [8:0] want);
      comparisons++;
      if (seen !== want)
      begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic give_verdict;
      if (bad_count == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Result, zero, digit carry, carry; subtraction adds the two's complement
   function automatic logic [10:0] arith(input logic [16:0] t);
      logic [7:0] bb;
      logic [8:0] s;
      logic [4:0] n;
      bb = t[16] ? ~t[7:0] : t[7:0];
      s = t[15:8] + bb + t[16];
      n = t[11:8] + bb[3:0] + t[16];
      return {s[7:0], s[7:0] == 8'h00, n[4], s[8]};
   endfunction

   // Flagless write: only the writable bits take the value, at either mirror
   task automatic wr(input csfr_op_e o, input logic [7:0] a, input logic [2:0] bs,
      input logic [7:0] val, input logic [8:0] addr);
      csfr_datapath_model_i.instr(o, a, ~a, bs, 1'b1, addr);
      if (addr == STATUS_ADDR_BANK0 || addr == STATUS_ADDR_BANK1)
         exp_status = (exp_status & ~STATUS_WRITABLE) | (val & STATUS_WRITABLE);
      chk(alu_result, val);
      chk(status_value, exp_status);
   endtask

   initial
   begin
      reset_n = 1'b0;
      bad_count = 0;
      comparisons = 0;
      repeat (6) @(negedge core_clk);
      chk(status_value, STATUS_RESET);
      chk(alu_result, 8'h00);
      reset_n = 1'b1;
      exp_status = STATUS_RESET;
      csfr_datapath_model_i.ev(1'b1, 1'b0, 1'b0, 1'b1);
      exp_status[4:3] = 2'b10;
      chk(status_value, exp_status);
      // A frozen core must ignore the time-out pulse
      csfr_datapath_model_i.ev(1'b0, 1'b1, 1'b0, 1'b0);
      chk(status_value, exp_status);
      csfr_datapath_model_i.ev(1'b1, 1'b1, 1'b0, 1'b0);
      exp_status[4] = 1'b0;
      chk(status_value, exp_status);
      csfr_datapath_model_i.ev(1'b1, 1'b0, 1'b1, 1'b0);
      exp_status[4:3] = 2'b11;
      chk(status_value, exp_status);
      // A time-out in the same cycle as a watchdog clear still leaves time-out low
      csfr_datapath_model_i.ev(1'b1, 1'b1, 1'b1, 1'b0);
      exp_status[4:3] = 2'b01;
      chk(status_value, exp_status);
      csfr_datapath_model_i.ev(1'b1, 1'b0, 1'b0, 1'b1);
      exp_status[4:3] = 2'b10;
      chk(status_value, exp_status);
      wr(OP_MOVE, 8'hFF, 3'h0, 8'hFF, STATUS_ADDR_BANK1);
      wr(OP_MOVE, 8'h00, 3'h0, 8'h00, STATUS_ADDR_BANK0);
      wr(OP_MOVE, 8'hFF, 3'h0, 8'hFF, 9'h103);
      for (int i = 0; i < 8; i++)
      begin
         wr(OP_MOVE, {i[2:0], 5'h00}, 3'h0, {i[2:0], 5'h00}, STATUS_ADDR_BANK0);
         chk(direct_addr, {i[1:0], instr_file});
         chk(indirect_addr, {i[2], indirect_ptr});
      end
      for (int i = 0; i < 7; i++)
      begin
         r = arith(arith_tab[i]);
         csfr_datapath_model_i.instr(arith_tab[i][16] ? OP_SUB : OP_ADD, arith_tab[i][15:8],
            arith_tab[i][7:0], 3'h0, 1'b0, STATUS_ADDR_BANK0);
         exp_status[2:0] = r[2:0];
         chk(alu_result, r[10:3]);
         chk(status_value, exp_status);
      end
      // Result low bits 000 differ from the flags 010, so a leaked write shows
      wr(OP_MOVE, 8'hE0, 3'h0, 8'hE0, STATUS_ADDR_BANK0);
      r = arith(17'h00F01);
      csfr_datapath_model_i.instr(OP_ADD, 8'h0F, 8'h01, 3'h0, 1'b1, STATUS_ADDR_BANK1);
      exp_status = {r[10:8], exp_status[4:3], r[2:0]};
      chk(status_value, exp_status);
      wr(OP_MOVE, 8'hE7, 3'h0, 8'hE7, STATUS_ADDR_BANK0);
      csfr_datapath_model_i.instr(OP_CLR, 8'h5A, 8'h00, 3'h0, 1'b1, STATUS_ADDR_BANK0);
      exp_status = {3'b000, exp_status[4:3], 1'b1, exp_status[1:0]};
      chk(status_value, exp_status);
      v = 8'h81;
      csfr_datapath_model_i.instr(OP_ROTL, v, 8'h00, 3'h0, 1'b0, STATUS_ADDR_BANK0);
      chk(alu_result, {v[6:0], exp_status[0]});
      exp_status[0] = v[7];
      chk(status_value, exp_status);
      v = 8'h02;
      csfr_datapath_model_i.instr(OP_ROTR, v, 8'h00, 3'h0, 1'b0, STATUS_ADDR_BANK0);
      chk(alu_result, {exp_status[0], v[7:1]});
      exp_status[0] = v[0];
      chk(status_value, exp_status);
      for (int i = 0; i < 7; i++)
      begin
         csfr_datapath_model_i.instr(csfr_op_e'(zero_tab[i][27:24]), zero_tab[i][23:16],
            zero_tab[i][15:8], 3'h0, 1'b0, STATUS_ADDR_BANK0);
         exp_status[2] = (zero_tab[i][7:0] == 8'h00);
         chk(alu_result, zero_tab[i][7:0]);
         chk(status_value, exp_status);
      end
      wr(OP_SWAP, 8'h5A, 3'h0, 8'hA5, STATUS_ADDR_BANK1);
      // Bit 1 is clear here, so the set must really change the stored value
      wr(OP_BITSET, exp_status, 3'h1, exp_status | 8'h02, STATUS_ADDR_BANK0);
      wr(OP_BITCLR, exp_status, 3'h4, exp_status & 8'hEF, STATUS_ADDR_BANK0);
      wr(OP_MOVE, exp_status & 8'h3F, 3'h0, exp_status & 8'h3F,
         STATUS_ADDR_BANK0);
      // Reset from a written state must restore bank, cause and result values
      @(negedge core_clk);
      reset_n = 1'b0;
      @(negedge core_clk);
      reset_n = 1'b1;
      chk(status_value, STATUS_RESET);
      chk(alu_result, 8'h00);
      give_verdict();
   end

   initial
   begin
      #400000;
      bad_count++;
      give_verdict();
   end
endmodule
